// ==== design/pscfg_outdiv.sv ====
// output divider with glitch-free synchronous gate
`timescale 1ns/10ps
module pscfg_outdiv
   import pscfg_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic [1:0] div_code,
   input  wire logic       gate,
   output logic            vco,
   output logic            fout
);

   logic [2:0] cnt_q, cnt_d;
   logic [1:0] code_q, code_d;
   logic       fout_q, fout_d;
   logic       vco_q, vco_d;
   logic [2:0] half_m1;
   logic [3:0] hi_len_q, hi_len_d;

   // ----------------------------------------------------------------
   // divider
   // ----------------------------------------------------------------
   always_comb begin
      half_m1  = 3'((4'h1 << code_q) - 4'h1);
      cnt_d    = 3'(cnt_q + 3'h1);
      fout_d   = fout_q;
      code_d   = code_q;
      vco_d    = ~vco_q;
      hi_len_d = fout_q ? 4'(hi_len_q + 4'h1) : 4'h0;
      if (cnt_q == half_m1) begin
         cnt_d  = DIV_CNT_RST;
         code_d = div_code;
         // high phase always completes; rise only when enabled
         if (fout_q) begin
            fout_d = 1'b0;
         end else begin
            fout_d = gate;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q    <= DIV_CNT_RST;
         code_q   <= N_RST;
         fout_q   <= 1'b0;
         vco_q    <= 1'b0;
         hi_len_q <= 4'h0;
      end else begin
         cnt_q    <= cnt_d;
         code_q   <= code_d;
         fout_q   <= fout_d;
         vco_q    <= vco_d;
         hi_len_q <= hi_len_d;
      end
   end

   assign vco  = vco_q;
   assign fout = fout_q;

   a_fout_high_len: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $fell(fout_q) |-> $past(hi_len_q) == 4'((4'h1 << $past(code_q)) - 4'h1))
      else $error("output high phase has wrong length");

   a_fout_gated_rise: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(fout_q) |-> $past(gate))
      else $error("output rose while gate was low");

endmodule : pscfg_outdiv

// ==== design/pscfg_pkg.sv ====
// constants for the synthesizer configuration port
package pscfg_pkg;

   // ----------------------------------------------------------------
   // configuration fields
   // ----------------------------------------------------------------
   localparam int M_W   = 9;
   localparam int N_W   = 2;
   localparam int T_W   = 3;
   localparam int SH_W  = 14;
   localparam int SH_M_LSB = 0;
   localparam int SH_N_LSB = 9;
   localparam int SH_T_LSB = 11;

   localparam logic [8:0] M_RST = 9'h1ff;
   localparam logic [1:0] N_RST = 2'h3;
   localparam logic [2:0] T_RST = 3'h0;
   localparam logic [13:0] SH_RST = 14'h0000;

   // ----------------------------------------------------------------
   // pin synchroniser layout and idle levels
   // ----------------------------------------------------------------
   localparam int SY_W     = 16;
   localparam int SY_SCLK  = 0;
   localparam int SY_SDATA = 1;
   localparam int SY_SLOAD = 2;
   localparam int SY_PLOAD = 3;
   localparam int SY_M_LSB = 4;
   localparam int SY_N_LSB = 13;
   localparam int SY_GATE  = 15;
   // serial pins idle low, parallel pins and gate idle high
   localparam logic [15:0] SY_RST = 16'hfff8;

   // ----------------------------------------------------------------
   // test output selections
   // ----------------------------------------------------------------
   localparam logic [2:0] TEST_LOW   = 3'h0;
   localparam logic [2:0] TEST_SHMSB = 3'h1;
   localparam logic [2:0] TEST_VCO   = 3'h2;
   localparam logic [2:0] TEST_FOUT  = 3'h3;
   localparam logic [2:0] TEST_SCLK  = 3'h4;
   localparam logic [2:0] TEST_SLOAD = 3'h5;
   localparam logic [2:0] TEST_PLOAD = 3'h6;

   // ----------------------------------------------------------------
   // apb register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [11:0] ADDR_CFG   = 12'h000;
   localparam logic [11:0] ADDR_CTRL  = 12'h004;
   localparam logic [11:0] ADDR_SHIFT = 12'h008;
   localparam int CTRL_GATE_BIT = 0;
   localparam logic CTRL_GATE_RST = 1'b1;

   // ----------------------------------------------------------------
   // output divider
   // ----------------------------------------------------------------
   localparam int DIV_CNT_W = 3;
   localparam logic [2:0] DIV_CNT_RST = 3'h0;

endpackage : pscfg_pkg

// ==== design/pscfg_top.sv ====
// configuration port of the programmable clock synthesizer
`timescale 1ns/10ps
module pscfg_top
   import pscfg_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic        ser_clk,
   input  wire logic        ser_data,
   input  wire logic        ser_load,
   input  wire logic        par_load,
   input  wire logic [8:0]  loop_div_in,
   input  wire logic [1:0]  out_div_in,
   input  wire logic        out_gate,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic [8:0]       loop_div,
   output logic [1:0]       out_div,
   output logic             fout,
   output logic             test_out
);

   logic [15:0] sy1_q, sy2_q;
   logic        sclk_prev_q;
   logic [13:0] sh_q, sh_d;
   logic [8:0]  m_q, m_d;
   logic [1:0]  n_q, n_d;
   logic [2:0]  t_q, t_d;
   logic        test_q, test_d;
   logic        ctrl_gate_q, ctrl_gate_d;
   logic [31:0] prdata_q, prdata_d;
   logic        pready_q, pready_d;
   logic        pslverr_q, pslverr_d;
   logic        sclk_rise;
   logic        ser_data_s;
   logic        ser_load_s;
   logic        par_load_s;
   logic [8:0]  m_pins_s;
   logic [1:0]  n_pins_s;
   logic        gate_s;
   logic        vco_w;
   logic        fout_w;
   logic        apb_done;
   logic        apb_acc;
   logic [31:0] rd_val;
   logic        rd_err;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sy1_q       <= SY_RST;
         sy2_q       <= SY_RST;
         sclk_prev_q <= 1'b0;
      end else begin
         sy1_q       <= {out_gate, out_div_in, loop_div_in, par_load, ser_load, ser_data, ser_clk};
         sy2_q       <= sy1_q;
         sclk_prev_q <= sy2_q[SY_SCLK];
      end
   end

   assign sclk_rise  = sy2_q[SY_SCLK] & ~sclk_prev_q;
   assign ser_data_s = sy2_q[SY_SDATA];
   assign ser_load_s = sy2_q[SY_SLOAD];
   assign par_load_s = sy2_q[SY_PLOAD];
   assign m_pins_s   = sy2_q[SY_M_LSB +: M_W];
   assign n_pins_s   = sy2_q[SY_N_LSB +: N_W];
   assign gate_s     = sy2_q[SY_GATE];

   // ----------------------------------------------------------------
   // shift register and configuration latches
   // ----------------------------------------------------------------
   always_comb begin
      sh_d = sh_q;
      m_d  = m_q;
      n_d  = n_q;
      t_d  = t_q;
      if (sclk_rise) begin
         sh_d = {sh_q[SH_W-2:0], ser_data_s};
      end
      if (ser_load_s) begin
         m_d = sh_q[SH_M_LSB +: M_W];
         n_d = sh_q[SH_N_LSB +: N_W];
         t_d = sh_q[SH_T_LSB +: T_W];
      end
      // parallel path wins when both strobes are transparent
      if (!par_load_s) begin
         m_d = m_pins_s;
         n_d = n_pins_s;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sh_q <= SH_RST;
         m_q  <= M_RST;
         n_q  <= N_RST;
         t_q  <= T_RST;
      end else begin
         sh_q <= sh_d;
         m_q  <= m_d;
         n_q  <= n_d;
         t_q  <= t_d;
      end
   end

   // ----------------------------------------------------------------
   // output divider and test output
   // ----------------------------------------------------------------
   pscfg_outdiv u_outdiv (
      .sys_clk  (sys_clk),
      .sys_rst  (sys_rst),
      .div_code (n_q),
      .gate     (gate_s & ctrl_gate_q),
      .vco      (vco_w),
      .fout     (fout_w)
   );

   always_comb begin
      case (t_q)
         TEST_LOW:   test_d = 1'b0;
         TEST_SHMSB: test_d = sh_q[SH_W-1];
         TEST_VCO:   test_d = vco_w;
         TEST_FOUT:  test_d = fout_w;
         TEST_SCLK:  test_d = sy2_q[SY_SCLK];
         TEST_SLOAD: test_d = ser_load_s;
         TEST_PLOAD: test_d = par_load_s;
         default:    test_d = 1'b1;
      endcase
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         test_q <= 1'b0;
      end else begin
         test_q <= test_d;
      end
   end

   // ----------------------------------------------------------------
   // apb slave, one wait state
   // ----------------------------------------------------------------
   assign apb_acc  = psel & penable & ~pready_q;
   assign apb_done = psel & penable & pready_q;

   always_comb begin
      rd_err = 1'b0;
      case (paddr)
         ADDR_CFG:   rd_val = {18'h0_0000, t_q, n_q, m_q};
         ADDR_CTRL:  rd_val = {31'h0000_0000, ctrl_gate_q};
         ADDR_SHIFT: rd_val = {18'h0_0000, sh_q};
         default: begin
            rd_val = 32'h0000_0000;
            rd_err = 1'b1;
         end
      endcase
   end

   always_comb begin
      pready_d    = apb_acc;
      prdata_d    = prdata_q;
      pslverr_d   = 1'b0;
      ctrl_gate_d = ctrl_gate_q;
      if (apb_acc) begin
         prdata_d  = pwrite ? 32'h0000_0000 : rd_val;
         pslverr_d = rd_err;
      end
      if (apb_done && pwrite && paddr == ADDR_CTRL && pstrb[0]) begin
         ctrl_gate_d = pwdata[CTRL_GATE_BIT];
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready_q    <= 1'b0;
         prdata_q    <= 32'h0000_0000;
         pslverr_q   <= 1'b0;
         ctrl_gate_q <= CTRL_GATE_RST;
      end else begin
         pready_q    <= pready_d;
         prdata_q    <= prdata_d;
         pslverr_q   <= pslverr_d;
         ctrl_gate_q <= ctrl_gate_d;
      end
   end

   assign prdata   = prdata_q;
   assign pready   = pready_q;
   assign pslverr  = pslverr_q;
   assign loop_div = m_q;
   assign out_div  = n_q;
   assign fout     = fout_w;
   assign test_out = test_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_shift_on_rise: assert property (@(posedge sys_clk) disable iff (sys_rst)
      sclk_rise |=> sh_q == {$past(sh_q[SH_W-2:0]), $past(ser_data_s)})
      else $error("shift register did not take serial bit");

   a_shift_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !sclk_rise |=> $stable(sh_q))
      else $error("shift register moved without serial clock rise");

   a_serial_transp: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (ser_load_s && par_load_s) |=> (t_q == $past(sh_q[13:11]) && m_q == $past(sh_q[8:0])
         && n_q == $past(sh_q[10:9])))
      else $error("latches not following shift register");

   a_latch_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!ser_load_s && par_load_s) |=> ($stable(m_q) && $stable(n_q) && $stable(t_q)))
      else $error("configuration changed while both strobes hold");

   a_par_transp: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !par_load_s |=> (m_q == $past(m_pins_s) && n_q == $past(n_pins_s)))
      else $error("latches not following parallel pins");

   a_test_serial_only: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (t_q != $past(t_q)) |-> $past(ser_load_s))
      else $error("test selector changed without serial strobe");

   a_test_fout: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (t_q == TEST_FOUT) |=> test_q == $past(fout_w))
      else $error("test output does not follow synthesized output");

   a_apb_wait: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (psel && penable && !pready_q) |=> (pready_q ##1 !pready_q))
      else $error("apb answer not one cycle after access");

endmodule : pscfg_top

// ==== verification/pscfg_ctrl_model.sv ====
// external controller model driving the serial and parallel configuration pins
`timescale 1ns/10ps
module pscfg_ctrl_model
   import pscfg_pkg::*;
(
   input  wire logic       sys_clk,
   output logic            ser_clk,
   output logic            ser_data,
   output logic            ser_load,
   output logic            par_load,
   output logic [8:0]      loop_div_in,
   output logic [1:0]      out_div_in
);
   // ----------------------------------------------------------------
   // idle levels: serial low, parallel high
   // ----------------------------------------------------------------
   initial begin
      ser_clk     = 1'b0;
      ser_data    = 1'b0;
      ser_load    = 1'b0;
      par_load    = 1'b1;
      loop_div_in = 9'h1ff;
      out_div_in  = 2'h3;
   end

   // 160 ns link period, msb first
   task automatic ser_send(input logic [13:0] w);
      for (int i = 13; i >= 0; i--) begin
         ser_clk  <= 1'b0;
         ser_data <= w[i];
         repeat (8) @(posedge sys_clk);
         ser_clk <= 1'b1;
         repeat (8) @(posedge sys_clk);
      end
      ser_clk  <= 1'b0;
      ser_data <= 1'b0;
      repeat (8) @(posedge sys_clk);
   endtask : ser_send

   // serial clock stands still around the strobe
   task automatic ser_strobe();
      ser_load <= 1'b1;
      repeat (8) @(posedge sys_clk);
      ser_load <= 1'b0;
      repeat (8) @(posedge sys_clk);
   endtask : ser_strobe

   task automatic par_open(input logic [8:0] m, input logic [1:0] n);
      @(posedge sys_clk);
      loop_div_in <= m;
      out_div_in  <= n;
      par_load    <= 1'b0;
      repeat (8) @(posedge sys_clk);
   endtask : par_open

   // pins held past the rise, then released to pull-up
   task automatic par_close();
      par_load <= 1'b1;
      repeat (4) @(posedge sys_clk);
      loop_div_in <= 9'h1ff;
      out_div_in  <= 2'h3;
   endtask : par_close
endmodule : pscfg_ctrl_model

// ==== verification/testbench.sv ====
// self-checking bench for the synthesizer configuration port
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module testbench;
   import pscfg_pkg::*;
   logic        sys_clk, sys_rst, ser_clk, ser_data, ser_load, par_load, out_gate;
   logic [8:0]  loop_div_in, loop_div;
   logic [1:0]  out_div_in, out_div;
   logic [11:0] paddr;
   logic        psel, penable, pwrite, pready, pslverr, fout, test_out;
   logic [31:0] pwdata, prdata, r;
   logic [3:0]  pstrb;
   logic        er;
   int          n_errors, num_checks;

   pscfg_top u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .ser_clk(ser_clk), .ser_data(ser_data),
      .ser_load(ser_load), .par_load(par_load), .loop_div_in(loop_div_in), .out_div_in(out_div_in),
      .out_gate(out_gate), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .loop_div(loop_div), .out_div(out_div), .fout(fout), .test_out(test_out));
   pscfg_ctrl_model u_ctrl (.sys_clk(sys_clk), .ser_clk(ser_clk), .ser_data(ser_data),
      .ser_load(ser_load), .par_load(par_load), .loop_div_in(loop_div_in), .out_div_in(out_div_in));

   always #5 sys_clk = ~sys_clk;

   task automatic print_verdict();
      if (n_errors == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict

   // ----------------------------------------------------------------
   // apb master
   // ----------------------------------------------------------------
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int k;
      @(posedge sys_clk);
      psel    <= 1'b1;
      paddr   <= a;
      pwrite  <= wr;
      pwdata  <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         n_errors++;
         $display("BAD %0t apb timeout", $time);
         print_verdict();
      end else begin
         r  = prdata;
         er = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(r, e)
      `CHK(er, 1'b0)
   endtask : rd_chk

   // high time of fout in sys_clk cycles
   task automatic fout_high(input int e);
      int k, h;
      k = 0;
      h = 0;
      while (fout !== 1'b0 && k < 50) begin @(posedge sys_clk); k++; end
      while (fout !== 1'b1 && k < 100) begin @(posedge sys_clk); k++; end
      if (fout !== 1'b1) begin
         n_errors++;
         $display("BAD %0t fout never rose", $time);
         print_verdict();
      end else begin
         while (fout === 1'b1 && h < 50) begin @(posedge sys_clk); h++; end
         `CHK(h, e)
      end
   endtask : fout_high

   task automatic fout_quiet();
      int h;
      h = 0;
      repeat (20) @(posedge sys_clk);
      repeat (40) begin @(posedge sys_clk); if (fout !== 1'b0) h++; end
      `CHK(h, 0)
   endtask : fout_quiet

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      sys_rst = 1'b1;
      out_gate = 1'b1;
      paddr = 12'h000;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      pwdata = 32'h0000_0000;
      pstrb = 4'hf;
      n_errors = 0;
      num_checks = 0;
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd_chk(ADDR_CFG, 32'h0000_07ff);
      `CHK(loop_div, 9'h1ff)
      `CHK(out_div, 2'h3)
      `CHK(test_out, 1'b0)
      rd_chk(ADDR_CTRL, 32'h0000_0001);
      // write with lane 0 disabled must not touch the soft gate
      pstrb <= 4'he;
      apb(1'b1, ADDR_CTRL, 32'h0000_0000);
      pstrb <= 4'hf;
      rd_chk(ADDR_CTRL, 32'h0000_0001);
      apb(1'b0, 12'h00c, 32'h0000_0000);
      `CHK(er, 1'b1)
      apb(1'b1, ADDR_CFG, 32'h0000_0000);
      rd_chk(ADDR_CFG, 32'h0000_07ff);
      u_ctrl.ser_send(14'h3ca5);
      rd_chk(ADDR_SHIFT, 32'h0000_3ca5);
      `CHK(loop_div, 9'h1ff)
      u_ctrl.ser_strobe();
      rd_chk(ADDR_CFG, 32'h0000_3ca5);
      `CHK(loop_div, 9'h0a5)
      `CHK(out_div, 2'h2)
      `CHK(test_out, 1'b1)
      u_ctrl.ser_send(14'h055a);
      rd_chk(ADDR_SHIFT, 32'h0000_055a);
      `CHK(loop_div, 9'h0a5)
      u_ctrl.ser_strobe();
      `CHK(loop_div, 9'h15a)
      `CHK(out_div, 2'h2)
      `CHK(test_out, 1'b0)
      u_ctrl.par_open(9'h123, 2'h0);
      `CHK(loop_div, 9'h123)
      u_ctrl.par_open(9'h0f0, 2'h1);
      `CHK(loop_div, 9'h0f0)
      u_ctrl.par_close();
      repeat (8) @(posedge sys_clk);
      `CHK(loop_div, 9'h0f0)
      `CHK(out_div, 2'h1)
      rd_chk(ADDR_CFG, 32'h0000_02f0);
      for (int c = 0; c < 4; c++) begin
         u_ctrl.par_open(9'h055, c[1:0]);
         u_ctrl.par_close();
         repeat (20) @(posedge sys_clk);
         fout_high(1 << c);
      end
      apb(1'b1, ADDR_CTRL, 32'h0000_0000);
      fout_quiet();
      rd_chk(ADDR_CTRL, 32'h0000_0000);
      apb(1'b1, ADDR_CTRL, 32'h0000_0001);
      fout_high(8);
      out_gate <= 1'b0;
      fout_quiet();
      out_gate <= 1'b1;
      fout_high(8);
      // test output showing the parallel strobe
      u_ctrl.ser_send(14'h37ff);
      u_ctrl.ser_strobe();
      `CHK(test_out, 1'b1)
      u_ctrl.par_open(9'h1ff, 2'h3);
      `CHK(test_out, 1'b0)
      u_ctrl.par_close();
      repeat (8) @(posedge sys_clk);
      `CHK(test_out, 1'b1)
      // test output showing the shift register top bit
      u_ctrl.ser_send(14'h0fff);
      u_ctrl.ser_strobe();
      `CHK(test_out, 1'b0)
      u_ctrl.ser_send(14'h2000);
      rd_chk(ADDR_SHIFT, 32'h0000_2000);
      `CHK(test_out, 1'b1)
      `CHK(loop_div, 9'h1ff)
      print_verdict();
   end
endmodule : testbench
